// ===== flic_controller.sv
// four-level interrupt controller: flags, sampling, polling, priority and hardware call
//
// Overview of operation
// - each external input selects level or transition trigger by its own bit
// - vectoring clears an external flag only in transition mode; level follows pin
// - timer 0/1 flags set on rollover, cleared when their handler is vectored
// - serial request is receive-done OR transmit-done; hardware never clears them
// - software set or clear of a flag acts exactly like hardware doing it
// - per-source enable bits plus a global enable that masks everything
// - level is high bit then low bit: 00 lowest up to 11 highest
// - only a strictly higher level preempts; level 3 is never preempted
// - among pending requests the higher level is serviced first
// - equal levels: ext0, timer0, ext1, timer1, serial, timer2
// - flags sampled at state 5 phase 2, polled in the next machine cycle
// - call blocked by active equal/higher level, non-final cycle, exit or register write
// - blocked requests are not remembered; each poll uses fresh samples only
// - acknowledge issues a long call with a source-dependent vector
// - handler exit clears the current level's in-progress status
// - a plain subroutine return leaves the in-progress status untouched
// - level mode: low sample raises flag; edge mode: high then low sample
// - the call takes two machine cycles; at least three cycles to handler
// - single-interrupt latency above 3 and below 9 machine cycles
// - a higher request sampled during a call's first cycle is vectored right after it
`timescale 1ns/1ps
`default_nettype none
`include "flic_regs.svh"

module flic_controller (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic doubleSpeed,
  input wire logic [1:0] extRequestPinN,
  input wire logic [1:0] extTriggerSelect,
  input wire logic timer0Rollover,
  input wire logic timer1Rollover,
  input wire logic timer2OverflowFlag,
  input wire logic timer2ExternalFlag,
  input wire logic receiveDoneFlag,
  input wire logic transmitDoneFlag,
  input wire logic flagWrite,
  input wire logic [3:0] flagWriteMask,
  input wire logic [3:0] flagWriteData,
  input wire logic enableWrite,
  input wire logic [7:0] enableWriteData,
  input wire logic prioLowWrite,
  input wire logic [7:0] prioLowWriteData,
  input wire logic prioHighWrite,
  input wire logic [7:0] prioHighWriteData,
  input wire logic instrFinalCycle,
  input wire logic instrIsHandlerExit,
  output logic machineCycleEnd,
  output logic [1:0] extRequestFlag,
  output logic timer0OverflowFlag,
  output logic timer1OverflowFlag,
  output logic [7:0] interruptEnableReg,
  output logic [7:0] priorityLowBits,
  output logic [7:0] priorityHighBits,
  output logic [3:0] inProgress,
  output logic longCallStart,
  output logic longCallActive,
  output logic [15:0] vectorAddress
);
  import flic_pkg::*;

  // =========================================
  // helpers

  // in double speed one clock covers a whole state, so match on the state only
  function automatic logic atTick(input flic_tick_t t, input flic_tick_t target,
                                  input logic dbl);
    atTick = dbl ? (t[3:1] == target[3:1]) : (t == target);
  endfunction

  // level-major search, fixed order within a level
  function automatic logic [5:0] pickRequest(input logic [5:0] req,
                                             input logic [7:0] hi, input logic [7:0] lo);
    logic found;
    flic_level_t lvl;
    flic_src_t src;
    found = 1'b0;
    lvl = 2'b00;
    src = 3'h0;
    for (int l = 3; l >= 0; l--) begin
      for (int i = `FLIC_NUM_SRC - 1; i >= 0; i--) begin
        if (!found && req[i] && ({hi[i], lo[i]} == 2'(l))) begin
          src = 3'(i);
          lvl = 2'(l);
        end
      end
      if (!found && (lvl == 2'(l)) && req[src] && ({hi[src], lo[src]} == 2'(l))) begin
        found = 1'b1;
      end
    end
    pickRequest = {found, lvl, src};
  endfunction

  function automatic logic [2:0] topLevel(input logic [3:0] act);
    topLevel = 3'b000;
    for (int l = 0; l < 4; l++) begin
      if (act[l]) begin
        topLevel = {1'b1, 2'(l)};
      end
    end
  endfunction

  function automatic logic [15:0] vectorOf(input flic_src_t s);
    case (s)
      `FLIC_SRC_EXT0: vectorOf = `FLIC_VEC_EXT0;
      `FLIC_SRC_TMR0: vectorOf = `FLIC_VEC_TMR0;
      `FLIC_SRC_EXT1: vectorOf = `FLIC_VEC_EXT1;
      `FLIC_SRC_TMR1: vectorOf = `FLIC_VEC_TMR1;
      `FLIC_SRC_SER: vectorOf = `FLIC_VEC_SER;
      `FLIC_SRC_TMR2: vectorOf = `FLIC_VEC_TMR2;
      default: vectorOf = 16'h0000;
    endcase
  endfunction

  // =========================================
  // state
  flic_tick_t tick;
  flic_tick_t next_tick;
  logic [1:0] pinMeta;
  logic [1:0] pinSync;
  logic [1:0] extPinLast;
  logic [1:0] next_extPinLast;
  logic [1:0] next_extRequestFlag;
  logic next_timer0OverflowFlag;
  logic next_timer1OverflowFlag;
  logic [5:0] sampleReg;
  logic [5:0] next_sampleReg;
  logic [5:0] pollReg;
  logic [5:0] next_pollReg;
  logic [7:0] next_interruptEnableReg;
  logic [7:0] next_priorityLowBits;
  logic [7:0] next_priorityHighBits;
  logic writeSeen;
  logic next_writeSeen;
  logic [3:0] next_inProgress;
  flic_call_e callState;
  flic_call_e next_callState;
  logic [15:0] next_vectorAddress;
  logic tickEnd;
  logic tickSample;
  logic [5:0] pending;
  logic [5:0] pick;
  logic [2:0] top;
  logic finalCycle;
  logic exitNow;
  logic writeNow;
  logic instrBlock;
  logic levelBlock;
  logic grant;

  // =========================================
  // machine cycle timing
  always_comb begin
    flic_tick_t step;
    step = doubleSpeed ? `FLIC_STEP_DOUBLE : `FLIC_STEP_NORMAL;
    // compare with >= so an odd tick left by a speed change still wraps
    if ((tick + step) >= `FLIC_TICK_WRAP) begin
      next_tick = 4'h0;
    end else begin
      next_tick = tick + step;
    end
    tickSample = atTick(tick, `FLIC_TICK_SAMPLE, doubleSpeed);
    tickEnd = atTick(tick, `FLIC_TICK_LAST, doubleSpeed);
  end

  // =========================================
  // poll and blocking
  always_comb begin
    writeNow = enableWrite | prioLowWrite | prioHighWrite;
    // fresh samples only: a blocked request must still be set at the next poll
    pending = pollReg & interruptEnableReg[5:0] &
              {6{interruptEnableReg[`FLIC_EN_GLOBAL]}};
    pick = pickRequest(pending, priorityHighBits, priorityLowBits);
    top = topLevel(inProgress);
    // the call's own second cycle counts as the final cycle of an instruction
    case (callState)
      FLIC_CALL1: finalCycle = 1'b0;
      FLIC_CALL2: finalCycle = 1'b1;
      default: finalCycle = instrFinalCycle;
    endcase
    exitNow = (callState == FLIC_IDLE) && instrIsHandlerExit;
    instrBlock = !finalCycle || exitNow || writeSeen || writeNow;
    // an equal level never preempts, so a level 3 handler is never interrupted
    levelBlock = top[2] && (pick[4:3] <= top[1:0]);
    grant = tickEnd && pick[5] && !instrBlock && !levelBlock;
  end

  // =========================================
  // flags and samples
  always_comb begin
    logic [3:0] hwClr;
    logic [1:0] extEdge;
    hwClr = 4'h0;
    extEdge = 2'b00;
    if (grant) begin
      case (pick[2:0])
        `FLIC_SRC_EXT0: hwClr[`FLIC_FW_EXT0] = extTriggerSelect[0];
        `FLIC_SRC_TMR0: hwClr[`FLIC_FW_TMR0] = 1'b1;
        `FLIC_SRC_EXT1: hwClr[`FLIC_FW_EXT1] = extTriggerSelect[1];
        `FLIC_SRC_TMR1: hwClr[`FLIC_FW_TMR1] = 1'b1;
        default: hwClr = 4'h0;
      endcase
    end
    next_extRequestFlag = extRequestFlag;
    next_timer0OverflowFlag = timer0OverflowFlag;
    next_timer1OverflowFlag = timer1OverflowFlag;
    next_extPinLast = extPinLast;
    if (hwClr[`FLIC_FW_EXT0]) next_extRequestFlag[0] = 1'b0;
    if (hwClr[`FLIC_FW_EXT1]) next_extRequestFlag[1] = 1'b0;
    if (hwClr[`FLIC_FW_TMR0]) next_timer0OverflowFlag = 1'b0;
    if (hwClr[`FLIC_FW_TMR1]) next_timer1OverflowFlag = 1'b0;
    if (flagWrite) begin
      if (flagWriteMask[`FLIC_FW_EXT0]) next_extRequestFlag[0] = flagWriteData[`FLIC_FW_EXT0];
      if (flagWriteMask[`FLIC_FW_EXT1]) next_extRequestFlag[1] = flagWriteData[`FLIC_FW_EXT1];
      if (flagWriteMask[`FLIC_FW_TMR0]) next_timer0OverflowFlag = flagWriteData[`FLIC_FW_TMR0];
      if (flagWriteMask[`FLIC_FW_TMR1]) next_timer1OverflowFlag = flagWriteData[`FLIC_FW_TMR1];
    end
    // sets come last so an event is never lost to a clear in the same cycle
    if (timer0Rollover) next_timer0OverflowFlag = 1'b1;
    if (timer1Rollover) next_timer1OverflowFlag = 1'b1;
    if (tickSample) begin
      next_extPinLast = pinSync;
      extEdge = extPinLast & ~pinSync;
      for (int x = 0; x < 2; x++) begin
        // level mode: the pin sample overrides a software write in the same cycle
        if (!extTriggerSelect[x]) begin
          next_extRequestFlag[x] = ~pinSync[x];
        end else if (extEdge[x]) begin
          next_extRequestFlag[x] = 1'b1;
        end
      end
    end
    next_sampleReg = sampleReg;
    if (tickSample) begin
      next_sampleReg = {timer2OverflowFlag | timer2ExternalFlag,
                        receiveDoneFlag | transmitDoneFlag,
                        next_timer1OverflowFlag, next_extRequestFlag[1],
                        next_timer0OverflowFlag, next_extRequestFlag[0]};
    end
    next_pollReg = tickEnd ? sampleReg : pollReg;
  end

  // =========================================
  // enable and priority registers
  always_comb begin
    next_interruptEnableReg = enableWrite ? enableWriteData : interruptEnableReg;
    // unimplemented positions are not stored and read as zero
    next_priorityLowBits = prioLowWrite ? (prioLowWriteData & `FLIC_PRIO_IMPL_MASK)
                                        : priorityLowBits;
    next_priorityHighBits = prioHighWrite ? (prioHighWriteData & `FLIC_PRIO_IMPL_MASK)
                                          : priorityHighBits;
    // a register write holds off polling until its instruction's final cycle ends
    next_writeSeen = writeSeen;
    if (tickEnd && finalCycle) begin
      next_writeSeen = 1'b0;
    end else if (writeNow) begin
      next_writeSeen = 1'b1;
    end
  end

  // =========================================
  // hardware call and in-progress tracking
  always_comb begin
    next_callState = callState;
    next_inProgress = inProgress;
    next_vectorAddress = vectorAddress;
    // a plain return never reaches this block, so its level stays blocked
    if (tickEnd && exitNow && instrFinalCycle && top[2]) begin
      next_inProgress[top[1:0]] = 1'b0;
    end
    // the second call cycle may grant again, so a higher request chains on directly
    if (tickEnd) begin
      case (callState)
        FLIC_CALL1: next_callState = FLIC_CALL2;
        FLIC_CALL2: next_callState = FLIC_IDLE;
        default: next_callState = FLIC_IDLE;
      endcase
    end
    if (grant) begin
      next_callState = FLIC_CALL1;
      next_inProgress[pick[4:3]] = 1'b1;
      next_vectorAddress = vectorOf(pick[2:0]);
    end
  end

  // =========================================
  // pin synchroniser
  // pins idle high, so the flops reset high and no false edge follows reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta <= 2'b11;
      pinSync <= 2'b11;
    end else begin
      pinMeta <= extRequestPinN;
      pinSync <= pinMeta;
    end
  end

  // =========================================
  // registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick <= 4'h0;
      extPinLast <= 2'b11;
      extRequestFlag <= 2'b00;
      timer0OverflowFlag <= 1'b0;
      timer1OverflowFlag <= 1'b0;
      sampleReg <= 6'h00;
      pollReg <= 6'h00;
      interruptEnableReg <= `FLIC_RST_ENABLE;
      priorityLowBits <= `FLIC_RST_PRIO;
      priorityHighBits <= `FLIC_RST_PRIO;
      writeSeen <= 1'b0;
      inProgress <= 4'h0;
      callState <= FLIC_IDLE;
      vectorAddress <= 16'h0000;
      longCallStart <= 1'b0;
      longCallActive <= 1'b0;
      machineCycleEnd <= 1'b0;
    end else begin
      tick <= next_tick;
      extPinLast <= next_extPinLast;
      extRequestFlag <= next_extRequestFlag;
      timer0OverflowFlag <= next_timer0OverflowFlag;
      timer1OverflowFlag <= next_timer1OverflowFlag;
      sampleReg <= next_sampleReg;
      pollReg <= next_pollReg;
      interruptEnableReg <= next_interruptEnableReg;
      priorityLowBits <= next_priorityLowBits;
      priorityHighBits <= next_priorityHighBits;
      writeSeen <= next_writeSeen;
      inProgress <= next_inProgress;
      callState <= next_callState;
      vectorAddress <= next_vectorAddress;
      longCallStart <= grant;
      longCallActive <= (next_callState != FLIC_IDLE);
      machineCycleEnd <= tickEnd;
    end
  end

endmodule

`default_nettype wire

// ===== flic_regs.svh
// constants of the four-level interrupt controller: cycle timing, field positions, vectors
`ifndef FLIC_REGS_SVH
`define FLIC_REGS_SVH

// =========================================
// machine cycle timing
`define FLIC_OSC_PER_MC 12
`define FLIC_TICK_WRAP 4'hc
`define FLIC_TICK_SAMPLE 4'h9
`define FLIC_TICK_LAST 4'hb
`define FLIC_STEP_NORMAL 4'h1
`define FLIC_STEP_DOUBLE 4'h2

// =========================================
// enable and priority register fields
`define FLIC_NUM_SRC 6
`define FLIC_EN_GLOBAL 7
`define FLIC_RST_ENABLE 8'h00
`define FLIC_RST_PRIO 8'h00
`define FLIC_PRIO_IMPL_MASK 8'h3f

// =========================================
// source numbers, in polling order
`define FLIC_SRC_EXT0 3'h0
`define FLIC_SRC_TMR0 3'h1
`define FLIC_SRC_EXT1 3'h2
`define FLIC_SRC_TMR1 3'h3
`define FLIC_SRC_SER 3'h4
`define FLIC_SRC_TMR2 3'h5

// =========================================
// software flag write lanes
`define FLIC_FW_EXT0 0
`define FLIC_FW_TMR0 1
`define FLIC_FW_EXT1 2
`define FLIC_FW_TMR1 3

// =========================================
// vector addresses
`define FLIC_VEC_EXT0 16'h0003
`define FLIC_VEC_TMR0 16'h000b
`define FLIC_VEC_EXT1 16'h0013
`define FLIC_VEC_TMR1 16'h001b
`define FLIC_VEC_SER 16'h0023
`define FLIC_VEC_TMR2 16'h002b

`endif

// ===== flic_pkg.sv
// types shared by the four-level interrupt controller
package flic_pkg;
  typedef enum logic [1:0] {
    FLIC_IDLE = 2'b00,
    FLIC_CALL1 = 2'b01,
    FLIC_CALL2 = 2'b11
  } flic_call_e;
  typedef logic [1:0] flic_level_t;
  typedef logic [2:0] flic_src_t;
  typedef logic [3:0] flic_tick_t;
endpackage

// ===== flic_controller_sva.sv
// checker of call timing, gating and flag clearing of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "flic_regs.svh"
module flic_controller_sva (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic doubleSpeed,
  input wire logic [1:0] extTriggerSelect,
  input wire logic timer0Rollover,
  input wire logic prioHighWrite,
  input wire logic [7:0] prioHighWriteData,
  input wire logic instrFinalCycle,
  input wire logic instrIsHandlerExit,
  input wire logic machineCycleEnd,
  input wire logic [1:0] extRequestFlag,
  input wire logic timer0OverflowFlag,
  input wire logic [7:0] interruptEnableReg,
  input wire logic [7:0] priorityHighBits,
  input wire logic [3:0] inProgress,
  input wire logic longCallStart,
  input wire logic longCallActive,
  input wire logic [15:0] vectorAddress
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // =========================================
  // assertions
  chk_call_two_cycles: assert property (
    longCallStart && !doubleSpeed |-> machineCycleEnd
    ##12 (machineCycleEnd && longCallActive) ##12 machineCycleEnd) else $error("call length");
  chk_global_gate: assert property (
    longCallStart |-> $past(interruptEnableReg[`FLIC_EN_GLOBAL])) else $error("grant masked");
  chk_tmr0_clear: assert property (
    longCallStart && vectorAddress == `FLIC_VEC_TMR0 && !$past(timer0Rollover)
    |-> !timer0OverflowFlag) else $error("timer flag kept");
  chk_ext0_edge_clear: assert property (
    longCallStart && vectorAddress == `FLIC_VEC_EXT0 && extTriggerSelect[0]
    |-> !extRequestFlag[0]) else $error("edge flag kept");
  chk_exit_clears: assert property (
    |($past(inProgress) & ~inProgress) |-> $past(instrIsHandlerExit)) else $error("level lost");
  chk_higher_only: assert property (
    longCallStart |-> (inProgress ^ $past(inProgress)) > $past(inProgress))
    else $error("preempt by equal level");
  chk_final_cycle: assert property (
    longCallStart && !$past(longCallActive) |-> $past(instrFinalCycle))
    else $error("grant mid instruction");
  chk_prio_write: assert property (
    prioHighWrite |=> priorityHighBits == ($past(prioHighWriteData) & `FLIC_PRIO_IMPL_MASK))
    else $error("priority write");
  cov_grant: cover property (longCallStart);
  cov_fast: cover property (longCallStart && doubleSpeed);
  cov_exit: cover property ($fell(|inProgress));
endmodule
`default_nettype wire

// ===== flic_core_model.sv
// behavioural core facing the controller: instruction ends and handler exits
`timescale 1ns/1ps
`default_nettype none
module flic_core_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic machineCycleEnd,
  input wire logic longCallActive,
  input wire logic exitReq,
  input wire logic slowInstr,
  output logic instrFinalCycle,
  output logic instrIsHandlerExit
);
  logic [1:0] cyc;
  logic exitPend;
  logic goExit;
  // =========================================
  // four-cycle instructions stand for the longest ones, the worst final-cycle wait
  assign instrFinalCycle = instrIsHandlerExit | ~slowInstr | (cyc == 2'h3);
  // no instruction runs during the call, so an exit waits for it
  assign goExit = exitPend & instrFinalCycle & ~longCallActive;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cyc <= 2'h0;
      exitPend <= 1'b0;
      instrIsHandlerExit <= 1'b0;
    end else begin
      if (exitReq) begin
        exitPend <= 1'b1;
      end
      if (machineCycleEnd) begin
        cyc <= cyc + 2'h1;
        instrIsHandlerExit <= goExit;
        if (goExit) begin
          exitPend <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test_four_level_interrupt_controller.sv
// self-checking bench of the four-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "flic_regs.svh"
bind flic_controller flic_controller_sva chk_i (.core_clk(core_clk), .nrst(nrst),
  .doubleSpeed(doubleSpeed), .extTriggerSelect(extTriggerSelect),
  .timer0Rollover(timer0Rollover), .prioHighWrite(prioHighWrite),
  .prioHighWriteData(prioHighWriteData), .instrFinalCycle(instrFinalCycle),
  .instrIsHandlerExit(instrIsHandlerExit), .machineCycleEnd(machineCycleEnd),
  .extRequestFlag(extRequestFlag), .timer0OverflowFlag(timer0OverflowFlag),
  .interruptEnableReg(interruptEnableReg), .priorityHighBits(priorityHighBits),
  .inProgress(inProgress), .longCallStart(longCallStart),
  .longCallActive(longCallActive), .vectorAddress(vectorAddress));
module test_four_level_interrupt_controller;
  logic core_clk = 1'b0, nrst = 1'b0, dbl = 1'b0, slow = 1'b0, exitReq = 1'b0;
  logic roll0 = 1'b0, roll1 = 1'b0, t2o = 1'b0, t2e = 1'b0, rxd = 1'b0, txd = 1'b0;
  logic fw = 1'b0, ew = 1'b0, plw = 1'b0, phw = 1'b0;
  logic [1:0] pinN = 2'h3, trig = 2'h3;
  logic [3:0] fwd = 4'h0, fwm = 4'hf;
  logic [7:0] wd = 8'h00;
  logic fin, hex, mce, t0f, t1f, lcs, lca;
  logic [1:0] erf;
  logic [7:0] ier, plb, phb;
  logic [3:0] inp;
  logic [15:0] va;
  logic [31:0] seed = 32'h0e19, r;
  logic [15:0] vec [6] = '{`FLIC_VEC_EXT0, `FLIC_VEC_TMR0, `FLIC_VEC_EXT1,
    `FLIC_VEC_TMR1, `FLIC_VEC_SER, `FLIC_VEC_TMR2};
  logic [5:0] pend, pm;
  int lvl [6];
  int err_total = 0, total_checks = 0, cycleCount = 0, w;
  always #2 core_clk = ~core_clk;
  flic_core_model core (.core_clk(core_clk), .nrst(nrst), .machineCycleEnd(mce),
    .longCallActive(lca), .exitReq(exitReq), .slowInstr(slow), .instrFinalCycle(fin),
    .instrIsHandlerExit(hex));
  flic_controller dut (.core_clk(core_clk), .nrst(nrst), .doubleSpeed(dbl),
    .extRequestPinN(pinN), .extTriggerSelect(trig), .timer0Rollover(roll0),
    .timer1Rollover(roll1), .timer2OverflowFlag(t2o), .timer2ExternalFlag(t2e),
    .receiveDoneFlag(rxd), .transmitDoneFlag(txd), .flagWrite(fw), .flagWriteMask(fwm),
    .flagWriteData(fwd), .enableWrite(ew), .enableWriteData(wd), .prioLowWrite(plw),
    .prioLowWriteData(wd), .prioHighWrite(phw), .prioHighWriteData(wd),
    .instrFinalCycle(fin), .instrIsHandlerExit(hex), .machineCycleEnd(mce),
    .extRequestFlag(erf), .timer0OverflowFlag(t0f), .timer1OverflowFlag(t1f),
    .interruptEnableReg(ier), .priorityLowBits(plb), .priorityHighBits(phb),
    .inProgress(inp), .longCallStart(lcs), .longCallActive(lca), .vectorAddress(va));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int winner();
    int b;
    b = -1;
    for (int i = 0; i < 6; i++)
      if (pend[i] && (b < 0 || lvl[i] > lvl[b])) b = i;
    return b;
  endfunction
  task automatic clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // =========================================
  // register write: 0 enable, 1 low priority, 2 high priority
  task automatic wr(input int k, input logic [7:0] d);
    wd = d;
    {phw, plw, ew} = 3'b001 << k;
    clk(1);
    {phw, plw, ew} = 3'b000;
    clk(1);
  endtask
  // bounded waits, so a lost grant or exit cannot hang the run
  task automatic wait_grant();
    for (int n = 0; n < 400 && lcs !== 1'b1; n++) clk(1);
    chk(lcs, 1'b1);
  endtask
  task automatic do_exit(input logic [3:0] left = 4'h0);
    exitReq = 1'b1;
    clk(1);
    exitReq = 1'b0;
    for (int n = 0; n < 400 && inp !== left; n++) clk(1);
    chk(inp, left);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycleCount++;
    if (cycleCount == 30000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    clk(10);
    nrst = 1'b1;
    chk({ier, plb}, 16'h0000);
    chk({phb, inp, erf, t0f, t1f}, 16'h0000);
    for (int t = 0; t < 6; t++) begin
      wr(0, 8'h00);
      r = xs();
      pm = (t == 0) ? 6'h3f : r[5:0];
      fwm = (t == 0) ? 4'hf : r[15:12];
      {dbl, slow} = r[9:8];
      {roll0, roll1} = 2'b11;
      {rxd, txd} = {pm[4] & r[10], pm[4] & ~r[10]};
      {t2o, t2e} = {pm[5] & r[11], pm[5] & ~r[11]};
      clk(1);
      {roll0, roll1} = 2'b00;
      chk({t0f, t1f}, 2'b11);
      fw = 1'b1;
      fwd = pm[3:0];
      // lanes left out of the mask keep their value: ext flags 0, timer flags 1
      pm[3:0] = (pm[3:0] & fwm) | (~fwm & 4'ha);
      clk(1);
      fw = 1'b0;
      chk({erf, t0f, t1f}, {pm[2], pm[0], pm[1], pm[3]});
      wr(1, r[23:16] & 8'h3f);
      wr(2, r[31:24] & 8'h3f);
      chk({phb, plb}, {r[31:24] & 8'h3f, r[23:16] & 8'h3f});
      pend = pm;
      for (int i = 0; i < 6; i++) lvl[i] = 2 * r[24 + i] + r[16 + i];
      wr(0, 8'h3f);
      clk(60);
      chk(inp, 4'h0);
      wr(0, 8'hbf);
      chk(ier, 8'hbf);
      for (w = winner(); w >= 0; w = winner()) begin
        wait_grant();
        chk(va, vec[w]);
        chk(inp, 4'h1 << lvl[w]);
        pend[w] = 1'b0;
        chk({erf, t0f, t1f}, {pend[2], pend[0], pend[1], pend[3]});
        if (w == 4) {rxd, txd} = 2'b00;
        if (w == 5) {t2o, t2e} = 2'b00;
        clk(30);
        chk(inp, 4'h1 << lvl[w]);
        do_exit();
      end
    end
    wr(0, 8'h00);
    wr(1, 8'h00);
    wr(2, 8'h00);
    for (int e = 0; e < 2; e++) begin
      trig = e ? 2'b00 : 2'b11;
      clk(40);
      pinN[e] = 1'b0;
      clk(40);
      chk(erf[e], 1'b1);
      wr(0, e ? 8'h84 : 8'h81);
      wait_grant();
      chk(va, vec[2 * e]);
      chk(erf[e], e[0]);
      pinN[e] = 1'b1;
      clk(40);
      chk(erf[e], 1'b0);
      do_exit();
      wr(0, 8'h00);
    end
    // level 0 handler: an equal request waits, a level 3 request preempts
    fwm = 4'hf;
    wr(1, 8'h08);
    wr(2, 8'h08);
    fw = 1'b1;
    fwd = 4'h2;
    clk(1);
    fw = 1'b0;
    wr(0, 8'h8a);
    wait_grant();
    chk(va, `FLIC_VEC_TMR0);
    roll0 = 1'b1;
    clk(1);
    roll0 = 1'b0;
    clk(60);
    chk(inp, 4'h1);
    roll1 = 1'b1;
    clk(1);
    roll1 = 1'b0;
    wait_grant();
    chk(va, `FLIC_VEC_TMR1);
    chk(inp, 4'h9);
    fw = 1'b1;
    fwd = 4'h0;
    clk(1);
    fw = 1'b0;
    chk(t0f, 1'b0);
    do_exit(4'h1);
    do_exit();
    final_report();
  end
endmodule
`default_nettype wire
